// ---- src/port_b_func_select_port_c_dir.sv ----
// Port B pin function select and port C direction, APB slave.
// Assumes port data registers, port C function select and the
// peripheral units sit outside; all inputs synchronous to pclk.
//
// Summary of operation
// - Reserved function-select bits read zero
// - Pin 9: port, int 7, addr 21, trigger
// - Pin 8: port, int 6, addr 20, wait
// - Pin 7: port, int 5, addr 19, request
// - Pin 6: port, int 4, addr 18, acknowledge
// - Pin 5: port, int 3, disable 3, select 7
// - Pin 4: port, int 2, disable 2, select 6
// - Pin 3: port, int 1, disable 1, I2C data
// - Pin 2: port, int 0, disable 0, I2C clock
// - Pin 1: port or address bit 17
// - Pin 0: port or address bit 16
// - Pins 1,0 boot to address in expansion mode
// - Port C direction bit: 1 output, 0 input
// - Port C direction only for port pins
// - Port C direction resets to all zero
// - Port B direction for port pins, upper zero
`timescale 1ns/100ps
module port_b_func_select_port_c_dir #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pinmux_pkg::apb_req_t apb_req,
  output pinmux_pkg::apb_rsp_t apb_rsp,
  input wire logic ext_rom_off_boot,
  input wire logic [pinmux_pkg::PB_PINS-1:0] portb_pin_in,
  input wire logic [pinmux_pkg::PB_PINS-1:0] portb_gpio_out,
  output logic [pinmux_pkg::PB_PINS-1:0] portb_pad_oe,
  output logic [pinmux_pkg::PB_PINS-1:0] portb_pad_out,
  input wire logic [pinmux_pkg::PC_PINS-1:0] portc_is_gpio,
  input wire logic [pinmux_pkg::PC_PINS-1:0] portc_gpio_out,
  input wire logic [pinmux_pkg::PC_PINS-1:0] portc_addr_out,
  output logic [pinmux_pkg::PC_PINS-1:0] portc_pad_oe,
  output logic [pinmux_pkg::PC_PINS-1:0] portc_pad_out,
  input wire pinmux_pkg::periph_in_t periph_in,
  output pinmux_pkg::periph_out_t periph_out
);
  import pinmux_pkg::*;

  if (ADDR_W < 4 || ADDR_W > 12) begin : g_chk
    $error("ADDR_W must lie between 4 and 12");
  end

  typedef struct packed {
    logic [15:0] fsel_high;
    logic [15:0] fsel_low;
    logic [15:0] pc_dir;
    logic [15:0] pb_dir;
    logic [31:0] prdata;
    logic boot_done;
  } state_t;

  state_t st;
  state_t next_st;
  pin_fn_t fn [PB_PINS];
  logic [PB_PINS-1:0] pb_gpio;
  logic [PB_PINS-1:0] pb_per_oe;
  logic [PB_PINS-1:0] pb_per_out;
  logic [PB_PINS-1:0] addr_on_pin;
  logic setup;
  logic access;
  reg_id_t sel;

  // Only the low ADDR_W bits are decoded; upper bits alias
  function automatic reg_id_t reg_of(input logic [11:0] addr);
    logic [11:0] a;
    a = addr & 12'(((1 << ADDR_W) - 1));
    if (a == FSEL_HIGH_OFS) return reg_high;
    else if (a == FSEL_LOW_OFS) return reg_low;
    else if (a == PC_DIR_OFS) return reg_pc_dir;
    else if (a == PB_DIR_OFS) return reg_pb_dir;
    else return reg_none;
  endfunction : reg_of

  // Byte-lane merge that keeps reserved bits at zero
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wdata,
                                        input logic [3:0] strb,
                                        input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) v[7:0] = wdata[7:0];
    if (strb[1]) v[15:8] = wdata[15:8];
    return v & mask;
  endfunction : merge

  // Function of one port B pin from the two select registers
  function automatic pin_fn_t pin_fn(input int n,
                                     input logic [15:0] hi,
                                     input logic [15:0] lo);
    logic [1:0] c2;
    logic [2:0] c3;
    c2 = 2'h0;
    c3 = 3'h0;
    unique case (n)
      9: c2 = hi[PIN9_LSB +: 2];
      8: c2 = hi[PIN8_LSB +: 2];
      7: c2 = lo[PIN7_LSB +: 2];
      6: c2 = lo[PIN6_LSB +: 2];
      5: c2 = lo[PIN5_LSB +: 2];
      4: c2 = lo[PIN4_LSB +: 2];
      3: c3 = {hi[PIN3_TOP], lo[PIN3_LSB +: 2]};
      2: c3 = {hi[PIN2_TOP], lo[PIN2_LSB +: 2]};
      1: c2 = {1'b0, lo[PIN1_BIT]};
      default: c2 = {1'b0, lo[PIN0_BIT]};
    endcase
    if (n == 3 || n == 2) begin
      // Codes 011 and 101..111 are not allowed; pin left undriven
      unique case (c3)
        3'h0: return fn_gpio;
        3'h1: return fn_int;
        3'h2: return fn_out_dis;
        3'h4: return fn_i2c;
        default: return fn_bad;
      endcase
    end
    if (n <= 1) return (c2[0] ? fn_addr : fn_gpio);
    unique case (c2)
      2'h0: return fn_gpio;
      2'h1: return (n >= 6) ? fn_int : fn_int;
      2'h2: return (n >= 6) ? fn_addr : fn_out_dis;
      default: begin
        unique case (n)
          9: return fn_adc_trig;
          8: return fn_bus_wait;
          7: return fn_bus_req;
          6: return fn_bus_ack;
          default: return fn_chip_sel;
        endcase
      end
    endcase
  endfunction : pin_fn

  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign sel = reg_of(apb_req.paddr);

  // Zero-wait slave once the boot strap is taken
  assign apb_rsp.pready = st.boot_done;
  assign apb_rsp.pslverr = access && st.boot_done && (sel == reg_none);
  assign apb_rsp.prdata = st.prdata;

  // Register file, read capture and boot-strap load
  always_comb begin
    next_st = st;
    if (!st.boot_done) begin
      // Strap sampled in the first cycle after reset release
      next_st.boot_done = 1'b1;
      next_st.fsel_low[PIN1_BIT] = ext_rom_off_boot;
      next_st.fsel_low[PIN0_BIT] = ext_rom_off_boot;
    end else if (apb_req.psel && !apb_req.pwrite) begin
      // Reserved bits are stored as zero so reads give zero
      unique case (sel)
        reg_high: next_st.prdata = {16'h0000, st.fsel_high};
        reg_low: next_st.prdata = {16'h0000, st.fsel_low};
        reg_pc_dir: next_st.prdata = {16'h0000, st.pc_dir};
        reg_pb_dir: next_st.prdata = {16'h0000, st.pb_dir};
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end else if (access && apb_req.pwrite) begin
      unique case (sel)
        reg_high: next_st.fsel_high = merge(st.fsel_high,
          apb_req.pwdata, apb_req.pstrb, FSEL_HIGH_MASK);
        reg_low: next_st.fsel_low = merge(st.fsel_low,
          apb_req.pwdata, apb_req.pstrb, FSEL_LOW_MASK);
        reg_pc_dir: next_st.pc_dir = merge(st.pc_dir,
          apb_req.pwdata, apb_req.pstrb, PC_DIR_MASK);
        reg_pb_dir: next_st.pb_dir = merge(st.pb_dir,
          apb_req.pwdata, apb_req.pstrb, PB_DIR_MASK);
        default: next_st = st;
      endcase
    end
  end

  // Reset takes constants only; the strap comes in a cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.fsel_high <= FSEL_HIGH_RST;
      st.fsel_low <= FSEL_LOW_RST;
      st.pc_dir <= PC_DIR_RST;
      st.pb_dir <= PB_DIR_RST;
      st.prdata <= 32'h0000_0000;
      st.boot_done <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign addr_on_pin = {periph_in.addr_hi[5:2], 4'h0,
                        periph_in.addr_hi[1:0]};

  // Peripheral drive per pin; input-only functions leave it off
  always_comb begin
    for (int n = 0; n < PB_PINS; n++) begin
      fn[n] = pin_fn(n, st.fsel_high, st.fsel_low);
      pb_gpio[n] = (fn[n] == fn_gpio);
      pb_per_oe[n] = 1'b0;
      pb_per_out[n] = 1'b0;
      unique case (fn[n])
        fn_addr: begin
          pb_per_oe[n] = 1'b1;
          pb_per_out[n] = addr_on_pin[n];
        end
        fn_bus_ack: begin
          pb_per_oe[n] = 1'b1;
          pb_per_out[n] = periph_in.bus_ack;
        end
        fn_chip_sel: begin
          // Only for parts with mask ROM or no ROM
          pb_per_oe[n] = 1'b1;
          pb_per_out[n] = (n == 5) ? periph_in.chip_select_7
                                   : periph_in.chip_select_6;
        end
        fn_i2c: begin
          // Open drain: drive low only, released otherwise
          pb_per_oe[n] = (n == 3) ? periph_in.sda_drive_low
                                  : periph_in.scl_drive_low;
          pb_per_out[n] = 1'b0;
        end
        default: begin
          pb_per_oe[n] = 1'b0;
          pb_per_out[n] = 1'b0;
        end
      endcase
    end
  end

  // Pin levels to the units; unrouted inputs rest at the idle level
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      periph_out.ext_int[k] = (fn[k+2] == fn_int) ?
        portb_pin_in[k+2] : IDLE_LEVEL;
    end
    for (int k = 0; k < 4; k++) begin
      periph_out.output_disable[k] = (fn[k+2] == fn_out_dis) ?
        portb_pin_in[k+2] : IDLE_LEVEL;
    end
    periph_out.adc_trigger_in = (fn[9] == fn_adc_trig) ?
      portb_pin_in[9] : IDLE_LEVEL;
    periph_out.bus_wait_in = (fn[8] == fn_bus_wait) ?
      portb_pin_in[8] : IDLE_LEVEL;
    periph_out.bus_request_in = (fn[7] == fn_bus_req) ?
      portb_pin_in[7] : IDLE_LEVEL;
    periph_out.i2c_data_line = (fn[3] == fn_i2c) ?
      portb_pin_in[3] : IDLE_LEVEL;
    periph_out.i2c_clock_line = (fn[2] == fn_i2c) ?
      portb_pin_in[2] : IDLE_LEVEL;
  end

  // Port B: direction register applies to port pins only
  pad_select #(.WIDTH(PB_PINS)) u_portb_pads (
    .pclk(pclk),
    .presetn(presetn),
    .gpio_en(pb_gpio),
    .gpio_dir(st.pb_dir[PB_PINS-1:0]),
    .gpio_out(portb_gpio_out),
    .per_oe(pb_per_oe),
    .per_out(pb_per_out),
    .pad_oe(portb_pad_oe),
    .pad_out(portb_pad_out)
  );

  // Port C: non-port pins are address outputs
  pad_select #(.WIDTH(PC_PINS)) u_portc_pads (
    .pclk(pclk),
    .presetn(presetn),
    .gpio_en(portc_is_gpio),
    .gpio_dir(st.pc_dir),
    .gpio_out(portc_gpio_out),
    .per_oe({PC_PINS{1'b1}}),
    .per_out(portc_addr_out),
    .pad_oe(portc_pad_oe),
    .pad_out(portc_pad_out)
  );

  // Checks on routing and register behaviour
  a_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && !apb_req.pwrite && apb_rsp.pready && sel == reg_high)
      |-> (apb_rsp.prdata[31:12] == 20'h00000
           && apb_rsp.prdata[9:4] == 6'h00))
    else $error("reserved bits of high select read non-zero");

  a_pin9_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.fsel_high[3:2] == 2'h2) |-> (portb_pad_oe[9]
      && portb_pad_out[9] == periph_in.addr_hi[5]))
    else $error("pin 9 does not carry address bit 21");

  a_pin8_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.fsel_high[1:0] == 2'h3) |-> (!portb_pad_oe[8]
      && periph_out.bus_wait_in == portb_pin_in[8]))
    else $error("pin 8 wait input not routed");

  a_pin7_busreq: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.fsel_low[15:14] == 2'h3) |-> (!portb_pad_oe[7]
      && periph_out.bus_request_in == portb_pin_in[7]))
    else $error("pin 7 bus request not routed");

  a_pin6_ack: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.fsel_low[13:12] == 2'h3) |-> (portb_pad_oe[6]
      && portb_pad_out[6] == periph_in.bus_ack))
    else $error("pin 6 bus acknowledge not driven");

  a_pin5_cs: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.fsel_low[11:10] == 2'h3) |-> (portb_pad_oe[5]
      && portb_pad_out[5] == periph_in.chip_select_7))
    else $error("pin 5 chip select not driven");

  a_pin4_disable: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.fsel_low[9:8] == 2'h2) |-> (!portb_pad_oe[4]
      && periph_out.output_disable[2] == portb_pin_in[4]))
    else $error("pin 4 output disable not routed");

  a_pin3_i2c: assert property (
    @(posedge pclk) disable iff (!presetn)
    ({st.fsel_high[11], st.fsel_low[7:6]} == 3'h4) |-> (!portb_pad_out[3]
      && portb_pad_oe[3] == periph_in.sda_drive_low))
    else $error("pin 3 I2C data not open drain");

  a_pin2_int: assert property (
    @(posedge pclk) disable iff (!presetn)
    ({st.fsel_high[10], st.fsel_low[5:4]} == 3'h1) |-> (!portb_pad_oe[2]
      && periph_out.ext_int[0] == portb_pin_in[2]))
    else $error("pin 2 interrupt input not routed");

  a_pin1_addr: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.fsel_low[2] |-> (portb_pad_oe[1]
      && portb_pad_out[1] == periph_in.addr_hi[1]))
    else $error("pin 1 does not carry address bit 17");

  a_boot_strap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (presetn && !st.boot_done) // Release edge itself still in reset
      |=> (st.fsel_low[0] == $past(ext_rom_off_boot)
      && st.fsel_low[2] == $past(ext_rom_off_boot) && st.boot_done))
    else $error("boot strap not loaded into pin 1 and 0 modes");

  a_pc_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st.boot_done |-> (st.pc_dir == 16'h0000 && st.pb_dir == 16'h0000))
    else $error("direction registers not clear after reset");

  a_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && apb_req.pwrite && apb_rsp.pready && sel == reg_pc_dir
      && apb_req.pstrb[1:0] == 2'h3)
      |=> (st.pc_dir == $past(apb_req.pwdata[15:0])))
    else $error("direction write did not land next cycle");

endmodule : port_b_func_select_port_c_dir

// ---- src/pinmux_pkg.sv ----
// Constants, register map and carrier types of the port B function
// select and port C direction block.
// Assumes a 32-bit APB with registers on aligned words.
package pinmux_pkg;

  // Register byte offsets
  localparam logic [11:0] FSEL_HIGH_OFS = 12'h000;
  localparam logic [11:0] FSEL_LOW_OFS = 12'h004;
  localparam logic [11:0] PC_DIR_OFS = 12'h008;
  localparam logic [11:0] PB_DIR_OFS = 12'h00C;

  // Writable bits; the rest are reserved and read as zero
  localparam logic [15:0] FSEL_HIGH_MASK = 16'h0C0F;
  localparam logic [15:0] FSEL_LOW_MASK = 16'hFFF5;
  localparam logic [15:0] PC_DIR_MASK = 16'hFFFF;
  localparam logic [15:0] PB_DIR_MASK = 16'h03FF;

  // Values after reset
  localparam logic [15:0] FSEL_HIGH_RST = 16'h0000;
  localparam logic [15:0] FSEL_LOW_RST = 16'h0000;
  localparam logic [15:0] PC_DIR_RST = 16'h0000;
  localparam logic [15:0] PB_DIR_RST = 16'h0000;

  // Field positions
  localparam int PIN9_LSB = 2;
  localparam int PIN8_LSB = 0;
  localparam int PIN7_LSB = 14;
  localparam int PIN6_LSB = 12;
  localparam int PIN5_LSB = 10;
  localparam int PIN4_LSB = 8;
  localparam int PIN3_TOP = 11;
  localparam int PIN3_LSB = 6;
  localparam int PIN2_TOP = 10;
  localparam int PIN2_LSB = 4;
  localparam int PIN1_BIT = 2;
  localparam int PIN0_BIT = 0;

  localparam int PB_PINS = 10;
  localparam int PC_PINS = 16;

  // Level handed to a unit whose input pin is not routed to it
  localparam logic IDLE_LEVEL = 1'b1;

  typedef enum logic [3:0] {
    fn_gpio, fn_int, fn_addr, fn_adc_trig, fn_bus_wait, fn_bus_req,
    fn_bus_ack, fn_out_dis, fn_chip_sel, fn_i2c, fn_bad
  } pin_fn_t;

  typedef enum logic [2:0] {
    reg_high, reg_low, reg_pc_dir, reg_pb_dir, reg_none
  } reg_id_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // From the bus controller and the I2C unit toward the pins
  typedef struct packed {
    logic [5:0] addr_hi;     // address bits 21..16
    logic bus_ack;
    logic chip_select_7;
    logic chip_select_6;
    logic sda_drive_low;
    logic scl_drive_low;
  } periph_in_t;

  // From the pins toward the interrupt, bus, A/D and I2C units
  typedef struct packed {
    logic [7:0] ext_int;
    logic adc_trigger_in;
    logic bus_wait_in;
    logic bus_request_in;
    logic [3:0] output_disable;
    logic i2c_data_line;
    logic i2c_clock_line;
  } periph_out_t;

endpackage : pinmux_pkg

// ---- src/pad_select.sv ----
// Per-pin choice between the general-purpose port and a peripheral.
// Assumes the caller decodes which pins are general-purpose.
`timescale 1ns/100ps
module pad_select #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] gpio_en,
  input wire logic [WIDTH-1:0] gpio_dir,
  input wire logic [WIDTH-1:0] gpio_out,
  input wire logic [WIDTH-1:0] per_oe,
  input wire logic [WIDTH-1:0] per_out,
  output logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pad_out
);
  import pinmux_pkg::*;

  if (WIDTH < 1) begin : g_chk
    $error("pad_select needs at least one pin");
  end

  // Direction bit only counts while the pin is a port pin
  always_comb begin
    for (int n = 0; n < WIDTH; n++) begin
      pad_oe[n] = gpio_en[n] ? gpio_dir[n] : per_oe[n];
      pad_out[n] = gpio_en[n] ? gpio_out[n] : per_out[n];
    end
  end

  // A peripheral-owned pin ignores the direction register
  a_dir_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gpio_en == '0) |-> (pad_oe == per_oe))
    else $error("direction bit leaked onto a peripheral pin");

  a_dir_applied: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gpio_en == '1) |-> (pad_oe == gpio_dir && pad_out == gpio_out))
    else $error("port pin direction not taken from register");

endmodule : pad_select

// ---- dv/pin_side_model.sv ----
// Stand-in for the port B pins and the bus, A/D and I2C units.
// Assumes one clock; the sequence steps each cycle, so a stale
// route or a late sample shows up as a mismatch.
`timescale 1ns/100ps
module pin_side_model (
  input wire logic pclk,
  input wire logic presetn,
  output pinmux_pkg::periph_in_t periph_in,
  output logic [pinmux_pkg::PB_PINS-1:0] pin_level
);
  import pinmux_pkg::*;
  logic [15:0] seq;

  // Shift register; a fixed pattern could hide swapped pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= 16'h1D4B;
    end else begin
      seq <= {seq[14:0], seq[15] ^ seq[13] ^ seq[12] ^ seq[10]};
    end
  end

  // Unit outputs and pin levels both derive from the sequence
  assign periph_in = periph_in_t'(seq[10:0]);
  assign pin_level = seq[15:6] ^ seq[9:0];
endmodule : pin_side_model

// ---- dv/port_b_func_select_port_c_dir_bench.sv ----
// Self-checking bench: APB register tests and pin routing checks.
// Assumes pin_side_model plays the pins and units around the mux.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); \
  end \
end
module port_b_func_select_port_c_dir_bench;
  import pinmux_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic strap = 1'b1;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [9:0] pin_level, pb_oe, pb_out;
  logic [9:0] pb_gout = 10'h2B6;
  logic [15:0] pc_gpio = 16'h3C5A;
  logic [15:0] pc_gout = 16'h9F21;
  logic [15:0] pc_addr = 16'h6D0E;
  logic [15:0] pc_oe, pc_out, hi, lo, pbd, pcd;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h7};
  periph_in_t pin_unit;
  periph_out_t unit_in;
  int n_mismatch = 0;
  int cmp_count = 0;

  // 25 MHz clock
  always #20 pclk = ~pclk;

  port_b_func_select_port_c_dir port_b_func_select_port_c_dir_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ext_rom_off_boot(strap), .portb_pin_in(pin_level),
    .portb_gpio_out(pb_gout), .portb_pad_oe(pb_oe),
    .portb_pad_out(pb_out), .portc_is_gpio(pc_gpio),
    .portc_gpio_out(pc_gout), .portc_addr_out(pc_addr),
    .portc_pad_oe(pc_oe), .portc_pad_out(pc_out),
    .periph_in(pin_unit), .periph_out(unit_in));

  pin_side_model pin_side_model_inst (
    .pclk(pclk), .presetn(presetn), .periph_in(pin_unit),
    .pin_level(pin_level));

  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= 4'hF;
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never sees pready
    while (rsp.pready !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    `CHK("wait_states", 0, n)
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer

  // Upper half set on purpose: it must be dropped
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] rd;
    logic e;
    xfer(1'b1, a, {16'hFFFF, d}, rd, e);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] ex,
                      input logic ee);
    logic [31:0] rd;
    logic e;
    xfer(1'b0, a, 32'h0, rd, e);
    `CHK("prdata", ex, rd)
    `CHK("pslverr", ee, e)
  endtask : rchk

  task automatic setmux(input logic [15:0] h, input logic [15:0] l);
    hi = h;
    lo = l;
    wr(FSEL_HIGH_OFS, h);
    wr(FSEL_LOW_OFS, l);
  endtask : setmux

  // Expected pads and unit inputs from the shadow registers
  task automatic check_pads;
    logic [9:0] oe, o;
    logic [15:0] ce;
    logic [2:0] f;
    periph_out_t po;
    int i, k;
    for (k = 0; k < 2; k++) begin
      @(negedge pclk);
      oe = '0;
      o = '0;
      po = {$bits(po){IDLE_LEVEL}};
      for (i = 0; i < 10; i++) begin
        if (i > 7) f = 3'(hi >> (2 * (i - 8))) & 3'h3;
        else if (i > 3) f = 3'(lo >> (2 * i)) & 3'h3;
        else if (i > 1) f = {hi[i + 8], lo[2 * i + 1], lo[2 * i]};
        else f = {2'h0, lo[2 * i]};
        if (f == 3'h0) begin
          oe[i] = pbd[i];
          o[i] = pb_gout[i];
        end else if (i < 2) begin
          oe[i] = 1'b1;
          o[i] = pin_unit.addr_hi[i];
        end else if (f == 3'h1) begin
          po.ext_int[i - 2] = pin_level[i];
        end else if (f == 3'h2 && i > 5) begin
          oe[i] = 1'b1;
          o[i] = pin_unit.addr_hi[i - 4];
        end else if (f == 3'h2) begin
          po.output_disable[i - 2] = pin_level[i];
        end else if (i == 3 && f == 3'h4) begin
          po.i2c_data_line = pin_level[3];
          oe[3] = pin_unit.sda_drive_low;
        end else if (i == 2 && f == 3'h4) begin
          po.i2c_clock_line = pin_level[2];
          oe[2] = pin_unit.scl_drive_low;
        end else if (i > 3) begin
          case (i)
            9: po.adc_trigger_in = pin_level[9];
            8: po.bus_wait_in = pin_level[8];
            7: po.bus_request_in = pin_level[7];
            6: o[6] = pin_unit.bus_ack;
            5: o[5] = pin_unit.chip_select_7;
            default: o[4] = pin_unit.chip_select_6;
          endcase
          oe[i] = (i < 7);
        end
      end
      ce = pc_gpio & pcd | ~pc_gpio;
      `CHK("portb_pad_oe", oe, pb_oe)
      `CHK("portb_pad_out", o & oe, pb_out & oe)
      `CHK("periph_out", po, unit_in)
      `CHK("portc_pad_oe", ce, pc_oe)
      `CHK("portc_pad_out", (pc_gpio & pc_gout | ~pc_gpio & pc_addr) & ce,
           pc_out & ce)
    end
  endtask : check_pads

  // Watchdog: the tests need well under 2,000 cycles
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end

  initial begin
    logic [2:0] c;
    logic [2:0] p;
    int i;
    {hi, lo, pbd, pcd} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(FSEL_LOW_OFS, 32'h00000005, 1'b0);
    rchk(FSEL_HIGH_OFS, 32'h00000000, 1'b0);
    $display("test strap_boot done");
    @(posedge pclk);
    presetn <= 1'b0;
    strap <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(FSEL_LOW_OFS, 32'h00000000, 1'b0);
    rchk(PC_DIR_OFS, 32'h00000000, 1'b0);
    check_pads();
    $display("test reset_values done");
    wr(FSEL_HIGH_OFS, 16'hFFFF);
    rchk(FSEL_HIGH_OFS, 32'h00000C0F, 1'b0);
    wr(FSEL_LOW_OFS, 16'hFFFF);
    rchk(FSEL_LOW_OFS, 32'h0000FFF5, 1'b0);
    wr(PB_DIR_OFS, 16'hFFFF);
    rchk(PB_DIR_OFS, 32'h000003FF, 1'b0);
    wr(PC_DIR_OFS, 16'hA5C3);
    rchk(PC_DIR_OFS, 32'h0000A5C3, 1'b0);
    wr(12'h010, 16'h1234);
    rchk(12'h010, 32'h00000000, 1'b1);
    wr(PB_DIR_OFS, 16'h0155);
    pbd = 16'h0155;
    pcd = 16'hA5C3;
    $display("test registers done");
    // Chip select codes used: the bench plays a mask-ROM part
    for (c = 3'h0; c < 3'h4; c++) begin
      setmux({12'h000, c[1:0], c[1:0]}, {{4{c[1:0]}}, 8'h00});
      check_pads();
    end
    $display("test two_bit_fields done");
    for (i = 0; i < 6; i++) begin
      p = codes[i];
      c = 3'(i);
      setmux({4'h0, p[2], p[2], 10'h000},
             {8'h00, p[1:0], p[1:0], 1'b0, c[0], 1'b0, c[0]});
      check_pads();
    end
    $display("test three_bit_fields done");
    wr(PC_DIR_OFS, 16'h5A3C);
    pcd = 16'h5A3C;
    check_pads();
    $display("test port_c_direction done");
    close_out();
  end
endmodule : port_b_func_select_port_c_dir_bench
